// ---- hw/snvm_defines.svh ----
/*
 * Constants of the serial memory core: opcodes, status bit positions,
 * reset values and timing counts.
 * Assumes a 40 MHz core clock; included by the shifter and the core.
 */
`ifndef SNVM_DEFINES_SVH
`define SNVM_DEFINES_SVH

////////////////////////////////////////////////////////////////////////
// Opcodes
`define SNVM_WRITE_ENABLE_CMD 8'h06
`define SNVM_STATUS_READ_CMD 8'h05
`define SNVM_PROGRAM_CMD 8'h02
`define SNVM_PAGE_CLEAR_CMD 8'h42
`define SNVM_ARRAY_CLEAR_CMD_A 8'h60
`define SNVM_ARRAY_CLEAR_CMD_B 8'hc7
`define SNVM_SLEEP_CMD 8'hb9
`define SNVM_WAKE_CMD 8'hab

////////////////////////////////////////////////////////////////////////
// Status byte layout and reset values
`define SNVM_BUSY_BIT 0
`define SNVM_LATCH_BIT 1
`define SNVM_LATCH_RESET 1'h0
`define SNVM_ERASED 8'hff

////////////////////////////////////////////////////////////////////////
// Sizes and timing
`define SNVM_PAGE_BYTES 32
`define SNVM_MEM_BYTES 4096
`define SNVM_CLK_NS 25
`define SNVM_WAKE_DELAY_US 75
`define SNVM_WAKE_DELAY_CYC \
    ((`SNVM_WAKE_DELAY_US * 1000 + `SNVM_CLK_NS - 1) / `SNVM_CLK_NS)
`define SNVM_PROG_CYC 64

`endif

// ---- hw/snvm_link_if.sv ----
/*
 * Signals between the serial-clock shifter and the core.
 * Assumes the core synchronises the toggle and partial flag; the byte is read once the toggle lands.
 */
`timescale 1ns/1ps
`default_nettype none

interface snvm_link_if;
    logic [7:0] rx_byte;
    logic rx_tgl;
    logic part_bits;
    logic [7:0] stat_byte;
    logic stat_ok;
    modport link (output rx_byte, output rx_tgl, output part_bits,
                  input stat_byte, input stat_ok);
    modport core (input rx_byte, input rx_tgl, input part_bits,
                  output stat_byte, output stat_ok);
endinterface : snvm_link_if

`default_nettype wire

// ---- hw/snvm_pkg.sv ----
/*
 * Types shared by the serial memory core.
 * Assumes nothing of its surroundings.
 */
package snvm_pkg;
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_write = 2'b01,
        st_hold = 2'b10
    } snvm_state_t;
    typedef enum logic [1:0] {
        op_prog = 2'b00,
        op_pclr = 2'b01,
        op_aclr = 2'b10
    } snvm_op_t;
endpackage : snvm_pkg

// ---- hw/snvm_spi_link.sv ----
/*
 * Serial-clock side: shifts in bytes, flags a partial byte, sends the
 * status byte back. Assumes modes 0/3; chip select high clears the frame state, not the byte hand-off.
 */
`timescale 1ns/1ps
`default_nettype none
`include "snvm_defines.svh"

module snvm_spi_link (
    input wire logic sck_in,
    input wire logic cs_n_in,
    input wire logic sdi_in,
    input wire logic rst_in,
    output logic sdo_out,
    output logic sdo_oe_out,
    snvm_link_if.link lk
);
    import snvm_pkg::*;
    logic [2:0] bit_q, bit_d;
    logic [6:0] sh_q, sh_d;
    logic first_q, first_d;
    logic rd_q, rd_d;
    logic tgl_q, tgl_d;
    logic [7:0] rx_q, rx_d;
    logic part_q, part_d;
    logic [7:0] byte_w;
    logic [8:0] st1_q, st2_q;
    logic sdo_d;

    ////////////////////////////////////////////////////////////////////
    // Next shift state, sampled on rising sck
    always_comb begin
        byte_w = {sh_q, sdi_in};
        bit_d = bit_q + 3'h1;
        sh_d = byte_w[6:0];
        first_d = first_q;
        rd_d = rd_q;
        tgl_d = tgl_q;
        rx_d = rx_q;
        part_d = (bit_d != 3'h0);
        if (bit_q == 3'h7) begin // [RQ24]
            first_d = 1'h1;
            tgl_d = ~tgl_q;
            rx_d = byte_w;
            if (!first_q && byte_w == `SNVM_STATUS_READ_CMD && st2_q[8]) begin
                rd_d = 1'h1;
            end
        end
    end

    // Frame state, cleared while chip select is high
    always_ff @(posedge sck_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            bit_q <= 3'h0;
            sh_q <= 7'h0;
            first_q <= 1'h0;
            rd_q <= 1'h0;
        end else begin
            bit_q <= bit_d;
            sh_q <= sh_d;
            first_q <= first_d;
            rd_q <= rd_d;
        end
    end

    // Byte hand-off, kept across frames
    always_ff @(posedge sck_in or posedge rst_in) begin
        if (rst_in) begin
            tgl_q <= 1'h0;
            rx_q <= 8'h0;
            part_q <= 1'h0;
        end else begin
            tgl_q <= tgl_d;
            rx_q <= rx_d;
            part_q <= part_d;
        end
    end

    // Status from the core, two stages
    always_ff @(posedge sck_in) begin
        st1_q <= {lk.stat_ok, lk.stat_byte};
        st2_q <= st1_q;
    end

    ////////////////////////////////////////////////////////////////////
    // Status bits out on falling sck, msb first
    always_comb begin
        sdo_d = rd_q & st2_q[3'h7 - bit_q]; // [RQ24]
    end

    always_ff @(negedge sck_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            sdo_out <= 1'h0;
            sdo_oe_out <= 1'h0;
        end else begin
            sdo_out <= sdo_d;
            sdo_oe_out <= rd_q;
        end
    end

    assign lk.rx_byte = rx_q;
    assign lk.rx_tgl = tgl_q;
    assign lk.part_bits = part_q;

endmodule : snvm_spi_link

`default_nettype wire

// ---- hw/snvm_top.sv ----
/*
 * Serial memory core: frame decoding, write latch, self-timed program
 * and clear cycles, sleep and wake, and the storage array.
 * Assumes a host SPI master; sck is unrelated to core_clk_in.
 */
`timescale 1ns/1ps
`default_nettype none
`include "snvm_defines.svh"

// Operation
// RQ1: Program while latch clear is dropped at chip-select rise.
// RQ2: Host gives a new chip-select fall after an ignored program.
// RQ3: Host sends write enable and program in separate select frames.
// RQ4: Latch sets only at select rise after a whole write enable.
// RQ5: Program frame is opcode, 16-bit address msb first, data bytes.
// RQ6: Host raises select in the sck low time after the last bit.
// RQ7: Select rise after a valid program frame starts the write cycle.
// RQ8: While busy, only the status read is served.
// RQ9: Status bit zero is one while busy, zero after.
// RQ10: Each data byte steps only the low five address bits, wrapping.
// RQ11: Over 32 bytes, the last 32 win within the page.
// RQ12: Under 32 bytes, other bytes of the page stay unchanged.
// RQ13: Latch clears when a cycle completes.
// RQ14: Page clear with latch set makes the 32-byte page all ones.
// RQ15: Page clear has two address bytes; low five bits ignored.
// RQ16: Page clear starts at select rise; busy reports its end.
// RQ17: Two opcodes clear the whole array, no address, latch needed.
// RQ18: Array clear starts at select rise; busy held until done.
// RQ19: Select rise after sleep opcode enters the sleep state.
// RQ20: While asleep only the wake opcode is obeyed.
// RQ21: Wake acts on eighth sck rise; commands wait 75 us after.
// RQ22: Latch is clear after reset.
// RQ23: Select rise mid-byte fails the frame; latch kept.
// RQ24: Msb first, sampled on rising sck, driven on falling sck.
module snvm_top #(
    parameter int PROG_CYC = `SNVM_PROG_CYC,
    parameter int MEM_BYTES = `SNVM_MEM_BYTES,
    parameter int PAGE_BYTES = `SNVM_PAGE_BYTES
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic spi_sck_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_sdi_in,
    output logic spi_sdo_out,
    output logic spi_sdo_oe_out,
    output logic busy_flag_out,
    output logic write_latch_out,
    output logic sleep_out,
    input wire logic [$clog2(MEM_BYTES)-1:0] mem_rd_addr_in,
    output logic [7:0] mem_rd_data_out
);
    import snvm_pkg::*;
    localparam int AW = $clog2(MEM_BYTES);
    localparam int PW = $clog2(PAGE_BYTES);
    localparam int WW = $clog2(`SNVM_WAKE_DELAY_CYC + 1);
    localparam int TW = $clog2(PROG_CYC + 1);

    logic [4:0] cs_s_q;
    logic [2:0] tg_s_q;
    logic [1:0] pt_s_q;
    logic cs_hi, frame_end, byte_ev, part;
    logic [2:0] cnt_q, cnt_d;
    logic bad_q, bad_d;
    logic [7:0] opc_q, opc_d;
    logic [15:0] adr_q, adr_d;
    logic [PAGE_BYTES-1:0] mask_q, mask_d;
    logic pb_we;
    logic [7:0] pbuf [PAGE_BYTES];
    snvm_state_t state_q, state_d;
    snvm_op_t op_q, op_d;
    logic [AW-1:0] idx_q, idx_d;
    logic [TW-1:0] tmr_q, tmr_d;
    logic latch_q, latch_d;
    logic sleep_q, sleep_d;
    logic [WW-1:0] wake_q, wake_d;
    logic busy_q, stat_ok_q;
    logic ready, accept, is_aclr, last;
    logic we;
    logic [AW-1:0] wa;
    logic [7:0] wd;
    logic [7:0] mem [MEM_BYTES];

    snvm_link_if lk ();

    ////////////////////////////////////////////////////////////////////
    // Serial-clock shifter
    snvm_spi_link u_link (
        .sck_in(spi_sck_in),
        .cs_n_in(spi_cs_n_in),
        .sdi_in(spi_sdi_in),
        .rst_in(rst_in),
        .sdo_out(spi_sdo_out),
        .sdo_oe_out(spi_sdo_oe_out),
        .lk(lk.link)
    );

    ////////////////////////////////////////////////////////////////////
    // Crossings; select gets two extra stages so the last byte lands
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            cs_s_q <= 5'h1f;
            tg_s_q <= 3'h0;
            pt_s_q <= 2'h0;
        end else begin
            cs_s_q <= {cs_s_q[3:0], spi_cs_n_in};
            tg_s_q <= {tg_s_q[1:0], lk.rx_tgl};
            pt_s_q <= {pt_s_q[0], lk.part_bits};
        end
    end

    assign cs_hi = cs_s_q[4];
    assign frame_end = cs_s_q[3] & ~cs_s_q[4];
    assign byte_ev = tg_s_q[1] ^ tg_s_q[2];
    assign part = pt_s_q[1];
    assign ready = (state_q == st_idle) && !sleep_q && (wake_q == '0);
    assign accept = frame_end && !bad_q && !part && ready; // [RQ23]
    assign is_aclr = (opc_q == `SNVM_ARRAY_CLEAR_CMD_A) ||
                     (opc_q == `SNVM_ARRAY_CLEAR_CMD_B);

    ////////////////////////////////////////////////////////////////////
    // Frame collection: opcode, address, data into the page buffer
    always_comb begin
        cnt_d = cnt_q;
        bad_d = bad_q;
        opc_d = opc_q;
        adr_d = adr_q;
        mask_d = mask_q;
        pb_we = 1'h0;
        if (cs_hi) begin
            cnt_d = 3'h0;
            bad_d = 1'h0;
        end else if (byte_ev) begin
            if (cnt_q != 3'h7) begin
                cnt_d = cnt_q + 3'h1;
            end
            if (!ready) begin
                bad_d = 1'h1; // [RQ8] [RQ20]
            end else if (cnt_q == 3'h0) begin
                opc_d = lk.rx_byte;
                mask_d = '0;
            end else if (cnt_q == 3'h1) begin
                adr_d[15:8] = lk.rx_byte; // [RQ5]
            end else if (cnt_q == 3'h2) begin
                adr_d[7:0] = lk.rx_byte;
            end else if (opc_q == `SNVM_PROGRAM_CMD) begin
                pb_we = 1'h1;
                mask_d[adr_q[PW-1:0]] = 1'h1; // [RQ12]
                adr_d[PW-1:0] = adr_q[PW-1:0] + 1'h1; // [RQ10] [RQ11]
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            cnt_q <= 3'h0;
            bad_q <= 1'h0;
            opc_q <= 8'h0;
            adr_q <= 16'h0;
            mask_q <= '0;
        end else begin
            cnt_q <= cnt_d;
            bad_q <= bad_d;
            opc_q <= opc_d;
            adr_q <= adr_d;
            mask_q <= mask_d;
        end
    end

    // Page buffer, later bytes overwrite earlier ones
    always_ff @(posedge core_clk_in) begin
        if (pb_we) begin
            pbuf[adr_q[PW-1:0]] <= lk.rx_byte; // [RQ11]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Command execution, cycle sequencing, latch, sleep and wake
    always_comb begin
        state_d = state_q;
        op_d = op_q;
        idx_d = idx_q;
        tmr_d = tmr_q;
        latch_d = latch_q;
        sleep_d = sleep_q;
        wake_d = (wake_q != '0) ? wake_q - 1'h1 : wake_q;
        last = (op_q == op_aclr) ? (idx_q == AW'(MEM_BYTES - 1))
                                 : (&idx_q[PW-1:0]);
        if (byte_ev && !cs_hi && cnt_q == 3'h0 && sleep_q &&
            lk.rx_byte == `SNVM_WAKE_CMD) begin
            sleep_d = 1'h0; // [RQ21]
            wake_d = WW'(`SNVM_WAKE_DELAY_CYC);
        end
        case (state_q)
            st_idle: begin
                idx_d = '0;
                if (accept) begin
                    if (cnt_q == 3'h1 &&
                        opc_q == `SNVM_WRITE_ENABLE_CMD) begin
                        latch_d = 1'h1; // [RQ4]
                    end else if (cnt_q == 3'h1 &&
                                 opc_q == `SNVM_SLEEP_CMD) begin
                        sleep_d = 1'h1; // [RQ19]
                        latch_d = 1'h0;
                    end else if (latch_q && cnt_q >= 3'h4 &&
                                 opc_q == `SNVM_PROGRAM_CMD) begin
                        state_d = st_write; // [RQ7] [RQ1]
                        op_d = op_prog;
                    end else if (latch_q && cnt_q == 3'h3 &&
                                 opc_q == `SNVM_PAGE_CLEAR_CMD) begin
                        state_d = st_write; // [RQ16]
                        op_d = op_pclr;
                    end else if (latch_q && cnt_q == 3'h1 && is_aclr) begin
                        state_d = st_write; // [RQ17] [RQ18]
                        op_d = op_aclr;
                    end
                end
            end
            st_write: begin
                idx_d = idx_q + 1'h1;
                if (last) begin
                    state_d = st_hold;
                    tmr_d = TW'(PROG_CYC - 1);
                end
            end
            st_hold: begin
                if (tmr_q == '0) begin
                    state_d = st_idle;
                    latch_d = 1'h0; // [RQ13]
                end else begin
                    tmr_d = tmr_q - 1'h1;
                end
            end
            default: begin
                state_d = st_idle;
            end
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            state_q <= st_idle;
            op_q <= op_prog;
            idx_q <= '0;
            tmr_q <= '0;
            latch_q <= `SNVM_LATCH_RESET; // [RQ22]
            sleep_q <= 1'h0;
            wake_q <= '0;
            busy_q <= 1'h0;
            stat_ok_q <= 1'h0;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            idx_q <= idx_d;
            tmr_q <= tmr_d;
            latch_q <= latch_d;
            sleep_q <= sleep_d;
            wake_q <= wake_d;
            busy_q <= (state_d != st_idle); // [RQ9]
            stat_ok_q <= !sleep_d && (wake_d == '0); // [RQ20] [RQ21]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Array write port: masked program or erase to all ones
    always_comb begin
        we = 1'h0;
        wa = idx_q;
        wd = `SNVM_ERASED;
        if (state_q == st_write) begin
            case (op_q)
                op_prog: begin
                    wa = {adr_q[AW-1:PW], idx_q[PW-1:0]};
                    wd = pbuf[idx_q[PW-1:0]];
                    we = mask_q[idx_q[PW-1:0]]; // [RQ12]
                end
                op_pclr: begin
                    wa = {adr_q[AW-1:PW], idx_q[PW-1:0]}; // [RQ15]
                    we = 1'h1; // [RQ14]
                end
                default: begin
                    we = 1'h1; // [RQ17]
                end
            endcase
        end
    end

    // Storage and debug read port
    always_ff @(posedge core_clk_in) begin
        if (we) begin
            mem[wa] <= wd;
        end
        mem_rd_data_out <= mem[mem_rd_addr_in];
    end

    // Status byte toward the shifter
    always_comb begin
        lk.stat_byte = 8'h0;
        lk.stat_byte[`SNVM_BUSY_BIT] = busy_q; // [RQ9]
        lk.stat_byte[`SNVM_LATCH_BIT] = latch_q;
        lk.stat_ok = stat_ok_q; // [RQ8]
    end

    assign busy_flag_out = busy_q;
    assign write_latch_out = latch_q;
    assign sleep_out = sleep_q;

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    sequence s_prog_go;
        accept && latch_q && cnt_q >= 3'h4 && opc_q == `SNVM_PROGRAM_CMD;
    endsequence
    sequence s_pclr_go;
        accept && latch_q && cnt_q == 3'h3 && opc_q == `SNVM_PAGE_CLEAR_CMD;
    endsequence
    sequence s_cycle_done;
        state_q == st_hold && tmr_q == '0;
    endsequence

    a_prog_discard: assert property ( // [RQ1]
        accept && !latch_q && opc_q == `SNVM_PROGRAM_CMD
        |=> state_q == st_idle && !busy_q)
        else $error("program ran without latch");
    a_latch_set: assert property ( // [RQ4]
        accept && cnt_q == 3'h1 && opc_q == `SNVM_WRITE_ENABLE_CMD
        |=> latch_q)
        else $error("latch not set by write enable");
    a_latch_cause: assert property ( // [RQ4]
        $rose(latch_q) |-> $past(accept) &&
                           $past(opc_q) == `SNVM_WRITE_ENABLE_CMD)
        else $error("latch set without write enable");
    a_prog_start: assert property ( // [RQ7]
        s_prog_go |=> state_q == st_write && busy_q)
        else $error("program cycle did not start");
    a_busy_ignore: assert property ( // [RQ8]
        state_q != st_idle && frame_end |=> !$rose(latch_q) && !$rose(sleep_q))
        else $error("command obeyed while busy");
    a_cycle_end: assert property ( // [RQ13]
        s_cycle_done |=> !busy_q && !latch_q && state_q == st_idle)
        else $error("cycle end wrong");
    a_page_wrap: assert property ( // [RQ10]
        pb_we |=> adr_q[PW-1:0] == PW'($past(adr_q) + 16'h1) &&
                  adr_q[15:PW] == (16-PW)'($past(adr_q) >> PW))
        else $error("address step wrong");
    a_clear_span: assert property ( // [RQ16]
        s_pclr_go |=> ##31 (state_q == st_write && we && &idx_q[PW-1:0])
        ##1 state_q == st_hold)
        else $error("page clear length wrong");
    a_clear_data: assert property ( // [RQ14]
        state_q == st_write && op_q != op_prog |-> we && wd == 8'hff)
        else $error("clear not all ones");
    a_part_keep: assert property ( // [RQ23]
        frame_end && part && state_q == st_idle
        |=> $stable(latch_q) && state_q == st_idle)
        else $error("partial frame acted");
    a_sleep_enter: assert property ( // [RQ19]
        accept && cnt_q == 3'h1 && opc_q == `SNVM_SLEEP_CMD
        |=> sleep_q && !latch_q)
        else $error("sleep not entered");
    a_wake_hold: assert property ( // [RQ21]
        $fell(sleep_q) |-> wake_q == WW'(`SNVM_WAKE_DELAY_CYC) && !stat_ok_q)
        else $error("wake delay not loaded");

endmodule : snvm_top

`default_nettype wire

// ---- tb/snvm_host_model.sv ----
/*
 * Host controller model: drives select, serial clock and data in
 * mode 0, one select frame per call, and shifts in the data-out line.
 * Assumes the bench fills tx_q before calling frame.
 */
`timescale 1ns/1ps
`default_nettype none

module snvm_host_model (
    output logic sck_out,
    output logic cs_n_out,
    output logic sdi_out,
    input wire logic sdo_in
);
    logic [7:0] tx_q [0:39];
    logic [7:0] rx_q;

    ////////////////////////////////////////////////////////////////////
    // Idle: deselected, serial clock parked low
    initial begin
        sck_out = 1'b0;
        cs_n_out = 1'b1;
        sdi_out = 1'b1;
        rx_q = 8'h00;
    end

    // One frame of nbits, 15 ns serial clock only inside the frame
    task automatic frame(input int nbits);
        int i;
        #1; // Clear of the core clock edge
        cs_n_out = 1'b0; // Own falling edge per frame
        #20;
        for (i = 0; i < nbits; i++) begin
            sdi_out = tx_q[i / 8][7 - (i % 8)]; // Msb first
            #7.5;
            rx_q = {rx_q[6:0], sdo_in}; // Sampled at rising sck
            sck_out = 1'b1;
            #7.5;
            sck_out = 1'b0;
        end
        #3;
        cs_n_out = 1'b1; // Rise inside the sck low time
        sdi_out = ~sdi_out; // Released line shows no stale bit
    endtask : frame
endmodule : snvm_host_model

`default_nettype wire

// ---- tb/snvm_top_bench.sv ----
/*
 * Self-checking bench for the serial memory core: frames from the host
 * model, results seen on flags, status byte and the debug read port.
 * Assumes the host model in tb/ and a small hold count.
 */
`timescale 1ns/1ps
`default_nettype none

module snvm_top_bench;
    localparam int PROG = 4;
    logic core_clk_in;
    logic rst_in;
    logic [11:0] mem_rd_addr_in;
    logic sck, cs_n, sdi, sdo, sdo_oe, busy, latch, sleep;
    logic sdo_line;
    logic [7:0] rd_data;
    int fails = 0;
    int compares = 0;
    int i;

    snvm_top #(.PROG_CYC(PROG)) u_dut (
        .core_clk_in(core_clk_in), .rst_in(rst_in),
        .spi_sck_in(sck), .spi_cs_n_in(cs_n), .spi_sdi_in(sdi),
        .spi_sdo_out(sdo), .spi_sdo_oe_out(sdo_oe),
        .busy_flag_out(busy), .write_latch_out(latch),
        .sleep_out(sleep), .mem_rd_addr_in(mem_rd_addr_in),
        .mem_rd_data_out(rd_data)
    );

    snvm_host_model u_host (
        .sck_out(sck), .cs_n_out(cs_n), .sdi_out(sdi), .sdo_in(sdo_line)
    );

    // Undriven data-out line shows the inverse of the last bit
    assign sdo_line = sdo_oe ? sdo : ~sdo;

    ////////////////////////////////////////////////////////////////////
    // Core clock, 25 ns
    initial begin
        core_clk_in = 1'b0;
        forever #12.5 core_clk_in = ~core_clk_in;
    end

    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    // Verdict and end of run
    task automatic tally_and_finish();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish

    // Short frame of up to three bytes, then the inter-frame gap
    task automatic cmd(input logic [7:0] b0, input logic [7:0] b1,
                       input logic [7:0] b2, input int nbits);
        u_host.tx_q[0] = b0;
        u_host.tx_q[1] = b1;
        u_host.tx_q[2] = b2;
        u_host.frame(nbits);
        repeat (8) @(posedge core_clk_in);
    endtask : cmd

    // Program frame of n data bytes counting up from v
    task automatic prog(input logic [15:0] a, input logic [7:0] v,
                        input int n);
        int k;
        u_host.tx_q[0] = 8'h02;
        u_host.tx_q[1] = a[15:8];
        u_host.tx_q[2] = a[7:0];
        for (k = 0; k < n; k++) begin
            u_host.tx_q[3 + k] = v + 8'(k);
        end
        u_host.frame(8 * (3 + n));
        repeat (8) @(posedge core_clk_in);
    endtask : prog

    // Bounded wait for the end of a self-timed cycle
    task automatic wait_idle();
        int k;
        for (k = 0; k < 6000 && busy !== 1'b0; k++) begin
            @(posedge core_clk_in);
        end
        check(busy, 1'b0);
    endtask : wait_idle

    // Debug read of one array byte
    task automatic rd_mem(input logic [11:0] a, input logic [7:0] e);
        mem_rd_addr_in <= a;
        repeat (2) @(posedge core_clk_in);
        #1;
        check(rd_data, e);
    endtask : rd_mem

    // Whole-array clear with the latch set first
    task automatic aclr(input logic [7:0] op);
        cmd(8'h06, 8'h00, 8'h00, 8);
        cmd(op, 8'h00, 8'h00, 8);
        check(busy, 1'b1);
        wait_idle();
        check(latch, 1'b0);
        rd_mem(12'h010, 8'hff);
        rd_mem(12'hfff, 8'hff);
    endtask : aclr

    // Hang guard
    initial begin
        repeat (40000) @(posedge core_clk_in);
        fails++;
        tally_and_finish();
    end

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst_in <= 1'b1;
        mem_rd_addr_in <= 12'h000;
        repeat (6) @(posedge core_clk_in);
        rst_in <= 1'b0;
        repeat (6) @(posedge core_clk_in);
        check(latch, 1'b0);
        cmd(8'h06, 8'h00, 8'h00, 13);
        check(latch, 1'b0);
        cmd(8'h06, 8'h00, 8'h00, 8);
        check(latch, 1'b1);
        cmd(8'h05, 8'h00, 8'h00, 16);
        check(u_host.rx_q, 8'h02);
        aclr(8'h60);
        // Program refused with latch clear
        prog(16'h0010, 8'h11, 1);
        check(busy, 1'b0);
        rd_mem(12'h010, 8'hff);
        cmd(8'h06, 8'h00, 8'h00, 8);
        prog(16'h0010, 8'h5a, 1);
        wait_idle();
        rd_mem(12'h010, 8'h5a);
        aclr(8'hc7);
        // Wrapping program, sleep sent while busy
        cmd(8'h06, 8'h00, 8'h00, 8);
        prog(16'h003d, 8'ha0, 5);
        check(busy, 1'b1);
        cmd(8'hb9, 8'h00, 8'h00, 8);
        wait_idle();
        check(sleep, 1'b0);
        check(latch, 1'b0);
        for (i = 0; i < 5; i++) begin
            rd_mem(12'h020 + 12'((29 + i) % 32), 8'ha0 + 8'(i));
        end
        rd_mem(12'h022, 8'hff);
        rd_mem(12'h03c, 8'hff);
        // Over-long program: last 32 bytes win
        cmd(8'h06, 8'h00, 8'h00, 8);
        prog(16'h0040, 8'h40, 34);
        wait_idle();
        for (i = 0; i < 32; i++) begin
            rd_mem(12'h040 + 12'(i), 8'h40 + 8'(i < 2 ? i + 32 : i));
        end
        rd_mem(12'h060, 8'hff);
        // Page clear, address inside the page
        cmd(8'h06, 8'h00, 8'h00, 8);
        cmd(8'h42, 8'h00, 8'h47, 24);
        cmd(8'h05, 8'h00, 8'h00, 16);
        check(u_host.rx_q, 8'h03);
        wait_idle();
        check(latch, 1'b0);
        for (i = 0; i < 32; i++) begin
            rd_mem(12'h040 + 12'(i), 8'hff);
        end
        rd_mem(12'h03d, 8'ha0);
        // Sleep, refused commands, wake and its delay
        cmd(8'hb9, 8'h00, 8'h00, 8);
        check(sleep, 1'b1);
        cmd(8'h06, 8'h00, 8'h00, 8);
        check(latch, 1'b0);
        cmd(8'h05, 8'h00, 8'h00, 16);
        check(u_host.rx_q, 8'hff);
        cmd(8'hab, 8'h00, 8'h00, 8);
        check(sleep, 1'b0);
        cmd(8'h06, 8'h00, 8'h00, 8);
        check(latch, 1'b0);
        repeat (3000) @(posedge core_clk_in);
        cmd(8'h06, 8'h00, 8'h00, 8);
        check(latch, 1'b1);
        // Reset again in mid-run with the latch set
        rst_in <= 1'b1;
        repeat (2) @(posedge core_clk_in);
        rst_in <= 1'b0;
        repeat (6) @(posedge core_clk_in);
        check(latch, 1'b0);
        check(sleep, 1'b0);
        cmd(8'h05, 8'h00, 8'h00, 16);
        check(u_host.rx_q, 8'h00);
        tally_and_finish();
    end
endmodule : snvm_top_bench

`default_nettype wire
